// file: core/mcb_pkg.sv
// Purpose: Shared constants and types for the memory card bus front end.
// Assumes: Core clock ref_clk at 100 MHz; link clock supplied by the host.
// Notes: Register widths and latency limits are fixed in absolute time.
package mcb_pkg;
   localparam int CORE_CLK_MHZ = 100;
   // Latency limits in milliseconds, independent of the link clock rate.
   localparam int READ_ACCESS_MS = 100;
   localparam int WRITE_ACCESS_MS = 250;
   localparam longint READ_ACCESS_CYC = longint'(READ_ACCESS_MS) * 1000 * CORE_CLK_MHZ;
   localparam longint WRITE_ACCESS_CYC = longint'(WRITE_ACCESS_MS) * 1000 * CORE_CLK_MHZ;
   // Register widths.
   localparam int IDENT_W = 128;
   localparam int ADDR_W = 16;
   localparam int SPECIFIC_W = 128;
   localparam int FEATURE_W = 64;
   localparam int OPCOND_W = 32;
   // Command indices.
   localparam logic [5:0] GO_IDLE_CMD = 6'h00;
   localparam logic [5:0] SEND_ADDR_CMD = 6'h03;
   localparam logic [5:0] BUS_WIDTH_APP_CMD = 6'h06;
   localparam logic [5:0] READ_BLOCK_CMD = 6'h11;
   localparam logic [5:0] WRITE_BLOCK_CMD = 6'h18;
   localparam logic [5:0] OP_CONDITION_APP_CMD = 6'h29;
   localparam logic [5:0] DETECT_PULLUP_APP_CMD = 6'h2A;
   localparam logic [5:0] APP_CMD_PREFIX = 6'h37;
   // Response kinds.
   localparam logic [7:0] RESP_OK = 8'h00;
   localparam logic [7:0] RESP_IDLE = 8'h01;
   localparam logic [7:0] RESP_ILLEGAL = 8'h04;
   localparam logic [7:0] RESP_BUSY = 8'h80;
   typedef enum logic [2:0] {MCB_IDLE, MCB_READY, MCB_TRAN, MCB_READ, MCB_WRITE} mcb_state_e;
endpackage

// file: core/mcb_link_rx.sv
// Purpose: Link-domain command shifter: takes 48-bit command frames from the host.
// Assumes: Runs only on the host clock; frames begin with a 0 start bit.
// Notes: Delivers each frame to the core domain through a toggle handshake.
module mcb_link_rx
   import mcb_pkg::*;
(
   // Link clock and reset
   input wire logic linkClk,
   input wire logic nrst,
   // Serial input and select
   input wire logic cmdIn,
   input wire logic selectN,
   input wire logic spiMode,
   // Frame out
   output logic [5:0] frameIdx,
   output logic [31:0] frameArg,
   output logic frameToggle
);
   typedef struct packed {
      logic [46:0] shift;
      logic [5:0] count;
      logic busy;
      logic [5:0] idx;
      logic [31:0] arg;
      logic tog;
   } mcb_rx_s;
   mcb_rx_s r_ff, nxt_r;

   always_comb begin
      nxt_r = r_ff;
      // In SPI mode a deselected card ignores the line and drops any partial frame.
      if (spiMode && selectN) begin
         nxt_r.busy = 1'b0;
         nxt_r.count = 6'h00;
      end else if (!r_ff.busy) begin
         if (!cmdIn) begin
            nxt_r.busy = 1'b1;
            nxt_r.count = 6'h01;
            nxt_r.shift = '0;
         end
      end else begin
         nxt_r.shift = {r_ff.shift[45:0], cmdIn};
         nxt_r.count = r_ff.count + 6'h01;
         if (r_ff.count == 6'h2F) begin
            nxt_r.busy = 1'b0;
            nxt_r.idx = r_ff.shift[44:39];
            nxt_r.arg = r_ff.shift[38:7];
            nxt_r.tog = ~r_ff.tog;
         end
      end
   end

   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign frameIdx = r_ff.idx;
   assign frameArg = r_ff.arg;
   assign frameToggle = r_ff.tog;
endmodule

// file: core/mcb_front_end.sv
// Purpose: Card-side front end: command decode, card registers, pin control.
// Assumes: Host clock on linkClk; ref_clk at 100 MHz times all latencies.
// Notes: Responses and data paths beyond status are left to the flash core.
//
// Summary of operation
// - Upper data lines stay inputs until width set.
// - Detect pin input with pull-up after power-up.
// - Detect pull-up app command sets pull-up from arg bit 0.
// - SPI: respond only while select low.
// - SPI: commands in, status out serially.
// - Hold 128-bit card identity register.
// - Hold 16-bit relative address, host confirms.
// - Hold 128-bit card specific data register.
// - Hold 64-bit feature and 32-bit condition.
// - No relative address in SPI mode.
// - Enter idle after every power-on.
// - Go-idle command returns to idle.
// - Block read completes within 100 ms.
// - Block write completes within 250 ms.
// - Latencies fixed in time, not clock.
// - Idle ignores all but prefixed condition command.
// - SPI: reply byte shifted out when response crosses, not aligned to select.
module mcb_front_end
   import mcb_pkg::*;
#(
   parameter longint READ_CYC = READ_ACCESS_CYC,
   parameter longint WRITE_CYC = WRITE_ACCESS_CYC,
   parameter logic [IDENT_W-1:0] IDENT_VAL = 128'h0123456789ABCDEF0123456789ABCDEF, // Arbitrary value.
   parameter logic [SPECIFIC_W-1:0] SPECIFIC_VAL = 128'h00000000000000000000000000000000,
   parameter logic [FEATURE_W-1:0] FEATURE_VAL = 64'h0000000000000000,
   parameter logic [OPCOND_W-1:0] OPCOND_VAL = 32'h00FF8000,
   parameter logic [ADDR_W-1:0] PROPOSED_ADDR = 16'h0001
)
(
   // Core clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Link clock and pins
   input wire logic linkClk,
   input wire logic cmdIn,
   input wire logic detectOrData3Pin,
   input wire logic spiSelectN,
   // Mode strap
   input wire logic spiModeStrap,
   // Outputs
   output logic serialOutLine,
   output logic serialOutOe,
   output logic upperDataOe,
   output logic detectPullupEn,
   output logic [7:0] respCode,
   output logic respValid,
   output logic [ADDR_W-1:0] relativeAddressReg,
   output logic [IDENT_W-1:0] cardIdentityReg,
   output logic [SPECIFIC_W-1:0] cardSpecificDataReg,
   output logic [FEATURE_W-1:0] featureConfigReg,
   output logic [OPCOND_W-1:0] opConditionReg,
   output logic cardIdle
);
   // ----------------------------------------
   // Link-domain receiver
   // ----------------------------------------
   logic [5:0] frameIdx;
   logic [31:0] frameArg;
   logic frameToggle;
   logic linkSpi;

   mcb_link_rx u_rx (
      .linkClk(linkClk),
      .nrst(nrst),
      .cmdIn(cmdIn),
      .selectN(spiSelectN),
      .spiMode(linkSpi),
      .frameIdx(frameIdx),
      .frameArg(frameArg),
      .frameToggle(frameToggle)
   );

   // ----------------------------------------
   // Link-domain output and mode mirror
   // ----------------------------------------
   // The mode and response byte are held stable across a frame, so a two-stage
   // sync into the link domain is safe for the mode level; the byte is
   // qualified by a toggle that crosses first.
   typedef struct packed {
      logic spiS1;
      logic spiS2;
      logic togS1;
      logic togS2;
      logic togSeen;
      logic [7:0] outShift;
      logic [3:0] outCnt;
      logic outBit;
      logic outOe;
   } mcb_lk_s;
   mcb_lk_s l_ff, nxt_l;
   logic respTog_ff;
   logic [7:0] respHold_ff;
   logic spiMode_ff;

   always_comb begin
      nxt_l = l_ff;
      nxt_l.spiS1 = spiMode_ff;
      nxt_l.spiS2 = l_ff.spiS1;
      nxt_l.togS1 = respTog_ff;
      nxt_l.togS2 = l_ff.togS1;
      if (l_ff.togS2 != l_ff.togSeen) begin
         nxt_l.togSeen = l_ff.togS2;
         nxt_l.outShift = respHold_ff;
         nxt_l.outCnt = 4'h8;
      end else if (l_ff.outCnt != 4'h0) begin
         nxt_l.outBit = l_ff.outShift[7];
         nxt_l.outShift = {l_ff.outShift[6:0], 1'b1};
         nxt_l.outCnt = l_ff.outCnt - 4'h1;
      end else begin
         nxt_l.outBit = 1'b1;
      end
      // In SPI the output drives only while selected.
      nxt_l.outOe = l_ff.spiS2 ? ~spiSelectN : (l_ff.outCnt != 4'h0);
   end

   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
         l_ff <= '0;
      end else begin
         l_ff <= nxt_l;
      end
   end
   assign linkSpi = l_ff.spiS2;
   assign serialOutLine = l_ff.outBit;
   assign serialOutOe = l_ff.outOe;

   // ----------------------------------------
   // Core domain
   // ----------------------------------------
   typedef struct packed {
      mcb_state_e state;
      logic [1:0] togSync;
      logic togSeen;
      logic [1:0] cdSync;
      logic [1:0] strapSync;
      logic [1:0] strapWait;
      logic spiMode;
      logic appPending;
      logic wideBus;
      logic pullupEn;
      logic [ADDR_W-1:0] relAddr;
      logic [7:0] resp;
      logic respTog;
      logic respValid;
      logic [27:0] latCnt;
   } mcb_core_s;
   mcb_core_s c_ff, nxt_c;
   logic newFrame;
   logic [5:0] cmdIdx;

   assign spiMode_ff = c_ff.spiMode;
   assign respTog_ff = c_ff.respTog;
   assign respHold_ff = c_ff.resp;
   // Frame words stay stable long after the toggle, so they are read directly.
   assign newFrame = c_ff.togSync[1] != c_ff.togSeen;
   assign cmdIdx = frameIdx;

   always_comb begin
      nxt_c = c_ff;
      nxt_c.togSync = {c_ff.togSync[0], frameToggle};
      nxt_c.cdSync = {c_ff.cdSync[0], detectOrData3Pin};
      nxt_c.strapSync = {c_ff.strapSync[0], spiModeStrap};
      nxt_c.respValid = 1'b0;
      // Mode follows the strap until the synchroniser has filled, then it is frozen.
      if (c_ff.strapWait != 2'h3) begin
         nxt_c.strapWait = c_ff.strapWait + 2'h1;
         nxt_c.spiMode = c_ff.strapSync[1];
      end
      // Latency counters run in ref_clk cycles, so they hold whatever the link rate.
      if (c_ff.state == MCB_READ || c_ff.state == MCB_WRITE) begin
         if (c_ff.latCnt != 28'h0) begin
            nxt_c.latCnt = c_ff.latCnt - 28'h1;
         end else begin
            nxt_c.state = MCB_TRAN;
            nxt_c.resp = RESP_OK;
            nxt_c.respTog = ~c_ff.respTog;
            nxt_c.respValid = 1'b1;
         end
      end
      if (newFrame) begin
         nxt_c.togSeen = c_ff.togSync[1];
         nxt_c.appPending = 1'b0;
         nxt_c.respTog = ~c_ff.respTog;
         nxt_c.respValid = 1'b1;
         nxt_c.resp = RESP_ILLEGAL;
         if (cmdIdx == GO_IDLE_CMD) begin
            nxt_c.state = MCB_IDLE;
            nxt_c.wideBus = 1'b0;
            nxt_c.pullupEn = 1'b1;
            nxt_c.relAddr = '0;
            nxt_c.resp = RESP_IDLE;
         end else if (cmdIdx == APP_CMD_PREFIX) begin
            nxt_c.appPending = 1'b1;
            nxt_c.resp = (c_ff.state == MCB_IDLE) ? RESP_IDLE : RESP_OK;
         end else if (c_ff.state == MCB_IDLE) begin
            // Only the prefixed condition command leaves idle.
            if (c_ff.appPending && cmdIdx == OP_CONDITION_APP_CMD) begin
               nxt_c.state = c_ff.spiMode ? MCB_TRAN : MCB_READY;
               nxt_c.resp = RESP_OK;
            end else begin
               nxt_c.resp = RESP_IDLE;
            end
         end else if (c_ff.appPending && cmdIdx == DETECT_PULLUP_APP_CMD) begin
            nxt_c.pullupEn = frameArg[0];
            nxt_c.resp = RESP_OK;
         end else if (c_ff.appPending && cmdIdx == BUS_WIDTH_APP_CMD && !c_ff.spiMode) begin
            nxt_c.wideBus = frameArg[1];
            nxt_c.resp = RESP_OK;
         end else if (cmdIdx == SEND_ADDR_CMD && !c_ff.spiMode && c_ff.state == MCB_READY) begin
            // Card proposes, host's acceptance is moving on to transfer.
            nxt_c.relAddr = PROPOSED_ADDR;
            nxt_c.state = MCB_TRAN;
            nxt_c.resp = RESP_OK;
         end else if (cmdIdx == READ_BLOCK_CMD && c_ff.state == MCB_TRAN) begin
            nxt_c.state = MCB_READ;
            nxt_c.latCnt = 28'(READ_CYC - 1);
            nxt_c.resp = RESP_BUSY;
         end else if (cmdIdx == WRITE_BLOCK_CMD && c_ff.state == MCB_TRAN) begin
            nxt_c.state = MCB_WRITE;
            nxt_c.latCnt = 28'(WRITE_CYC - 1);
            nxt_c.resp = RESP_BUSY;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         c_ff <= '{state: MCB_IDLE, pullupEn: 1'b1, default: '0};
      end else begin
         c_ff <= nxt_c;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         upperDataOe <= 1'b0;
         detectPullupEn <= 1'b1;
         respCode <= '0;
         respValid <= 1'b0;
         relativeAddressReg <= '0;
         cardIdentityReg <= '0;
         cardSpecificDataReg <= '0;
         featureConfigReg <= '0;
         opConditionReg <= '0;
         cardIdle <= 1'b1;
      end else begin
         upperDataOe <= c_ff.wideBus && !c_ff.spiMode && c_ff.state == MCB_READ;
         detectPullupEn <= c_ff.pullupEn;
         respCode <= c_ff.resp;
         respValid <= c_ff.respValid;
         relativeAddressReg <= c_ff.spiMode ? '0 : c_ff.relAddr;
         cardIdentityReg <= IDENT_VAL;
         cardSpecificDataReg <= SPECIFIC_VAL;
         featureConfigReg <= FEATURE_VAL;
         opConditionReg <= OPCOND_VAL;
         cardIdle <= c_ff.state == MCB_IDLE;
      end
   end
endmodule

// file: verification/mcb_front_end_asserts.sv
// Purpose: Port-level checks for the memory card bus front end.
// Assumes: The mode strap changes only while nrst is low.
// Notes: Bound into every instance of the front end.
module mcb_front_end_asserts
   import mcb_pkg::*;
#(
   parameter logic [IDENT_W-1:0] IDENT_VAL = '0,
   parameter logic [SPECIFIC_W-1:0] SPECIFIC_VAL = '0,
   parameter logic [FEATURE_W-1:0] FEATURE_VAL = '0,
   parameter logic [OPCOND_W-1:0] OPCOND_VAL = '0
)
(
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic linkClk,
   // Watched pins
   input wire logic spiSelectN,
   input wire logic spiModeStrap,
   input wire logic serialOutOe,
   input wire logic upperDataOe,
   input wire logic detectPullupEn,
   input wire logic [7:0] respCode,
   input wire logic respValid,
   input wire logic [ADDR_W-1:0] relativeAddressReg,
   input wire logic [IDENT_W-1:0] cardIdentityReg,
   input wire logic [SPECIFIC_W-1:0] cardSpecificDataReg,
   input wire logic [FEATURE_W-1:0] featureConfigReg,
   input wire logic [OPCOND_W-1:0] opConditionReg,
   input wire logic cardIdle
);
   // Bench shortens both latencies to 40 cycles, so 60 leaves room for the crossing.
   localparam int BUSY_MAX = 60;
   a_ident_value: assert property (
      @(posedge ref_clk) disable iff (!nrst) $past(nrst, 2) |-> cardIdentityReg == IDENT_VAL)
      else $error("identity register value wrong");
   a_regs_value: assert property (
      @(posedge ref_clk) disable iff (!nrst) $past(nrst, 2) |-> cardSpecificDataReg == SPECIFIC_VAL
      && featureConfigReg == FEATURE_VAL && opConditionReg == OPCOND_VAL)
      else $error("specific, feature or condition register wrong");
   a_spi_no_addr: assert property (
      @(posedge ref_clk) disable iff (!nrst) spiModeStrap |-> relativeAddressReg == '0)
      else $error("relative address shown in serial mode");
   a_upper_lines_in: assert property (
      @(posedge ref_clk) disable iff (!nrst) cardIdle |-> !upperDataOe)
      else $error("upper data lines driven in idle");
   a_spi_desel_quiet: assert property (
      @(posedge linkClk) disable iff (!nrst) spiModeStrap && $past(spiSelectN) |-> !serialOutOe)
      else $error("serial output driven while deselected");
   a_idle_refuse: assert property (
      @(posedge ref_clk) disable iff (!nrst) respValid && cardIdle |-> respCode == RESP_IDLE)
      else $error("idle card answered with other than idle code");
   a_pullup_not_idle: assert property (
      @(posedge ref_clk) disable iff (!nrst) $changed(detectPullupEn) |-> !$past(cardIdle))
      else $error("pull-up changed while idle");
   a_busy_completes: assert property (
      @(posedge ref_clk) disable iff (!nrst) respValid && respCode == RESP_BUSY
      |-> ##[1:BUSY_MAX] (respValid && respCode == RESP_OK))
      else $error("block access did not complete in time");
endmodule

bind mcb_front_end mcb_front_end_asserts #(.IDENT_VAL(IDENT_VAL), .SPECIFIC_VAL(SPECIFIC_VAL),
   .FEATURE_VAL(FEATURE_VAL), .OPCOND_VAL(OPCOND_VAL)) u_chk (.ref_clk(ref_clk), .nrst(nrst),
   .linkClk(linkClk), .spiSelectN(spiSelectN), .spiModeStrap(spiModeStrap), .serialOutOe(serialOutOe),
   .upperDataOe(upperDataOe), .detectPullupEn(detectPullupEn), .respCode(respCode), .respValid(respValid),
   .relativeAddressReg(relativeAddressReg), .cardIdentityReg(cardIdentityReg),
   .cardSpecificDataReg(cardSpecificDataReg), .featureConfigReg(featureConfigReg),
   .opConditionReg(opConditionReg), .cardIdle(cardIdle));

// file: verification/mcb_host_model.sv
// Purpose: Host model that clocks command frames into the card.
// Assumes: The card samples on the rising link clock edge.
// Notes: The link clock stands still between frames.
module mcb_host_model (
   // Bench request
   input wire logic go,
   input wire logic [5:0] idx,
   input wire logic [31:0] arg,
   input wire logic useSel,
   // Card outputs
   input wire logic serialOutLine,
   input wire logic serialOutOe,
   // Link pins and status
   output logic linkClk,
   output logic cmdIn,
   output logic selectN,
   output logic busy,
   output logic [7:0] rxByte
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [79:0] frm;
   // The host side holds both reserved pins pulled up.
   logic [1:0] reservedPinPull = 2'h3;
   initial begin
      linkClk = 1'b0;
      cmdIn = 1'b1;
      selectN = 1'b1;
      busy = 1'b0;
      rxByte = 8'h00;
      forever begin
         @(posedge go);
         busy = 1'b1;
         // Trailing ones keep the clock running long enough for the reply byte.
         frm = {2'b01, idx, arg, 8'h01, 32'hFFFFFFFF};
         #1.3 selectN = ~useSel;
         repeat (80) begin
            cmdIn = frm[79];
            frm = {frm[78:0], 1'b1};
            #3 linkClk = 1'b1;
            #3 linkClk = 1'b0;
            if (serialOutOe === 1'b1) rxByte = {rxByte[6:0], serialOutLine};
         end
         selectN = 1'b1;
         cmdIn = 1'b1;
         busy = 1'b0;
      end
   end
endmodule

// file: verification/mcb_front_end_tb_top.sv
// Purpose: Self-checking bench for the memory card bus front end.
// Assumes: Block latencies shortened to 40 core cycles.
// Notes: Native mode runs first, then a reset into serial mode.
module mcb_front_end_tb_top import mcb_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic strap = 1'b0;
   logic go = 1'b0;
   logic useSel = 1'b1;
   logic sawWide = 1'b0;
   logic [5:0] idx = 6'h00;
   logic [31:0] arg = 32'h00000000;
   logic linkClk, cmdIn, selectN, busy, serOut, serOe, upOe, pullEn, respValid, cardIdle;
   logic [7:0] respCode, rxByte, lastResp;
   logic [15:0] relAddr;
   int n_mismatch = 0, cmp_count = 0, nResp = 0, cyc = 0, k, base;
   int seed = 32'hc73c;
   mcb_front_end #(.READ_CYC(40), .WRITE_CYC(40)) dut (.ref_clk(ref_clk), .nrst(nrst), .linkClk(linkClk),
      .cmdIn(cmdIn), .detectOrData3Pin(1'b1), .spiSelectN(selectN), .spiModeStrap(strap),
      .serialOutLine(serOut), .serialOutOe(serOe), .upperDataOe(upOe), .detectPullupEn(pullEn),
      .respCode(respCode), .respValid(respValid), .relativeAddressReg(relAddr), .cardIdentityReg(),
      .cardSpecificDataReg(), .featureConfigReg(), .opConditionReg(), .cardIdle(cardIdle));
   mcb_host_model host (.go(go), .idx(idx), .arg(arg), .useSel(useSel), .serialOutLine(serOut),
      .serialOutOe(serOe), .linkClk(linkClk), .cmdIn(cmdIn), .selectN(selectN), .busy(busy), .rxByte(rxByte));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   always @(negedge ref_clk) begin
      if (respValid === 1'b1) begin
         nResp++;
         lastResp = respCode;
      end
      if (upOe === 1'b1) sawWide = 1'b1;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
      cmp_count++;
      if (got !== e) begin
         n_mismatch++;
         $display("wrong value %s: expected %h, seen %h", nm, e, got);
      end
   endtask
   task automatic send(input logic [5:0] i, input logic [31:0] a);
      @(posedge ref_clk);
      #1 idx = i;
      arg = a;
      go = 1'b1;
      @(posedge ref_clk);
      #1 go = 1'b0;
      while (busy === 1'b1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic cmdExp(input logic [5:0] i, input logic [31:0] a, input logic [7:0] e);
      send(i, a);
      chk("respCode", 32'(e), 32'(lastResp));
      if (strap === 1'b0) chk("serial byte", 32'(e), 32'(rxByte));
   endtask
   task automatic app(input logic [5:0] i, input logic [31:0] a);
      send(APP_CMD_PREFIX, 32'h00000000);
      send(i, a);
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("cardIdle", 1, 32'(cardIdle));
      chk("pullup", 1, 32'(pullEn));
      chk("upper oe", 0, 32'(upOe));
      for (k = 0; k < 6; k++) cmdExp({1'b0, 5'($random(seed))}, $random(seed), RESP_IDLE);
      cmdExp(OP_CONDITION_APP_CMD, 32'h00000000, RESP_IDLE);
      $display("idle refusal test done");
      app(OP_CONDITION_APP_CMD, 32'h00000000);
      chk("cardIdle", 0, 32'(cardIdle));
      send(SEND_ADDR_CMD, 32'h00000000);
      chk("address", 1, 32'(relAddr));
      app(DETECT_PULLUP_APP_CMD, 32'h00000000);
      chk("pullup", 0, 32'(pullEn));
      app(DETECT_PULLUP_APP_CMD, 32'h00000001);
      chk("pullup", 1, 32'(pullEn));
      $display("setup test done");
      app(BUS_WIDTH_APP_CMD, 32'h00000002);
      for (k = 0; k < 2; k++) begin
         base = nResp;
         sawWide = 1'b0;
         cmdExp(k ? WRITE_BLOCK_CMD : READ_BLOCK_CMD, $random(seed), RESP_BUSY);
         repeat (50) @(posedge ref_clk);
         chk("responses", base + 2, nResp);
         chk("respCode", 32'(RESP_OK), 32'(lastResp));
         chk("wide oe", k ? 0 : 1, 32'(sawWide));
      end
      send(GO_IDLE_CMD, 32'h00000000);
      chk("cardIdle", 1, 32'(cardIdle));
      $display("transfer test done");
      @(posedge ref_clk);
      #1 nrst = 1'b0;
      strap = 1'b1;
      repeat (10) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("cardIdle", 1, 32'(cardIdle));
      base = nResp;
      useSel = 1'b0;
      send(APP_CMD_PREFIX, 32'h00000000);
      chk("responses", base, nResp);
      useSel = 1'b1;
      app(OP_CONDITION_APP_CMD, 32'h00000000);
      chk("cardIdle", 0, 32'(cardIdle));
      chk("address", 0, 32'(relAddr));
      send(GO_IDLE_CMD, 32'h00000000);
      chk("cardIdle", 1, 32'(cardIdle));
      $display("serial mode test done");
      tally_and_finish();
   end
endmodule
